// file: dv/apr_host_model.sv
`timescale 1ns/1ps
// =====================================================================
// host side: receives the characters sent on phase a
module apr_host_model #(
    parameter int BIT_CYC = 16
) (
    // clock
    input  wire logic  clk,
    // lines from the driver
    input  wire logic  a,
    input  wire logic  b,
    input  wire logic  busy,
    // received message
    output logic [7:0] msg [8],
    output int         nchar,
    output int         pcount,
    output logic       frame_err
);
    logic [8:0] sh;
    logic [1:0] ab_q;

    initial begin
        nchar = 0;
        pcount = 0;
        ab_q = 2'b00;
        frame_err = 1'b0;
    end
    // a new report clears the count before any pulse arrives
    always @(posedge busy) begin
        nchar = 0;
        pcount = 0;
    end
    // reversible counter; only after the message, so serial bits never count
    always @(posedge clk) begin
        if (busy && nchar == 8 && {a, b} != ab_q) begin
            pcount = ({a, b} == {~ab_q[0], ab_q[1]}) ? pcount + 1 : pcount - 1;
        end
        ab_q = {a, b};
    end
    // mid-bit sampling; takes all eight characters, ignores pulses after them
    always begin
        @(negedge a iff (busy && nchar < 8));
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            sh[i] = a;
        end
        frame_err = frame_err | ~sh[8] | ^sh[7:0]; // stop at mark, even parity
        msg[nchar] = sh[7:0];
        nchar++;
    end
endmodule // apr_host_model

// file: dv/test_apr_top.sv
`timescale 1ns/1ps
// =====================================================================
// report sequence, setup and alarm checks
module test_apr_top
    import apr_pkg::*;
;
    localparam int RQ = 200;
    localparam int ND = 100;
    localparam int BC = 16;
    logic clk = 0, arst_n = 0, req = 0, tup = 0, tdn = 0, lost = 0, gev = 0;
    logic eclr = 0, gclr = 0, mtclr = 0, son = 0;
    logic energ, pa, pb, pz, busy, valid, galm, sdone, sref, ferr;
    logic [4:0] eev = '0, ealm;
    logic [7:0] msg [8];
    apr_quad_t enc = '0;
    int nchar, pcnt, num_errors = 0, compares = 0;
    localparam longint PS = 0; // stored reference point of this bench

    apr_top #(.REQ_DELAY_CYC(RQ), .NORM_DELAY_CYC(ND), .BIT_CYC(BC), .INIT_STEP_CYC(4)) i_apr_top (
        .CLK(clk), .ARST_N(arst_n), .ABS_REPORT_REQUEST(req), .ENC_IN(enc), .ENC_P0(17'h0_0008),
        .ENC_TURN_UP(tup), .ENC_TURN_DN(tdn), .ENC_BACKUP_LOST(lost), .ENC_ALARM_EV(eev),
        .GEN_ALARM_EV(gev), .ENC_ALARM_CLEAR(eclr), .GENERAL_ALARM_CLEAR_INPUT(gclr),
        .MT_CLEAR_REQ(mtclr), .SERVO_ON(son), .SERVO_ENERGIZE(energ), .PHASE_A_OUT(pa),
        .PHASE_B_OUT(pb), .ORIGIN_PULSE_OUT(pz), .REPORT_BUSY(busy), .ABS_DATA_VALID(valid),
        .ENC_ALARM(ealm), .GEN_ALARM(galm), .SETUP_DONE(sdone), .SETUP_REFUSED(sref));
    apr_host_model #(.BIT_CYC(BC)) i_apr_host_model (.clk(clk), .a(pa), .b(pb), .busy(busy), .msg(msg),
        .nchar(nchar), .pcount(pcnt), .frame_err(ferr));

    // =====================================================================
    // helpers
    initial forever #5 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmp_pos(input string name, input longint exp, input longint got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    // host position; pulses per turn taken after the output division (1 here)
    function automatic longint host_pos(input longint m, input longint p0, input logic dir_neg);
        return (dir_neg ? -m : m) * APR_PULSES_PER_REV + p0 - PS;
    endfunction
    task automatic close_out();
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // =====================================================================
    // scenarios
    task automatic t_setup(input logic on);
        logic seen;
        son = on;
        mtclr = 1'b1;
        seen = 1'b0;
        repeat (3) begin
            cyc(1);
            mtclr = 1'b0;
            seen = seen | (on ? sref : sdone);
        end
        cmp("setup answer", 1, seen);
        cmp("valid", !on, valid);
        son = 1'b0;
    endtask
    task automatic t_report(input string s, input longint m);
        int t;
        logic [7:0] c;
        longint m_rx;
        son = 1'b1;
        req = 1'b1; // host asks for a report
        t = 0;
        do begin cyc(1); t++; end while (!(t > 8 && pa === 1'b0) && t < 400);
        cmp("start delay", 1, t >= RQ && t <= RQ + 12);
        cmp("energize early", 0, energ);
        t = 0;
        while (nchar != 8 && t < 2000) begin cyc(1); t++; end
        t = 0;
        while (busy !== 1'b0 && t < 2000) begin cyc(1); t++; end
        cmp("normal delay", 1, t >= ND - BC && t <= ND + 12);
        cmp("chars", 8, nchar);
        cmp("frame", 0, ferr);
        for (int i = 0; i < 8; i++) begin
            c = (i < 7) ? s[i] : 8'h0D;
            cmp("char", {^c[6:0], c[6:0]}, msg[i]);
        end
        cmp("initial pulses", 8, 16'(pcnt));
        m_rx = 0;
        for (int i = 2; i < 7; i++) begin
            m_rx = m_rx * 10 + longint'(msg[i][3:0]);
        end
        if (msg[1][6:0] == APR_CH_MINUS) begin
            m_rx = -m_rx;
        end
        cmp_pos("position", m * APR_PULSES_PER_REV + 8, host_pos(m_rx, pcnt, 1'b0));
        cmp_pos("position neg", -m * APR_PULSES_PER_REV + 8, host_pos(m_rx, pcnt, 1'b1));
        cyc(2);
        cmp("energize", 1, energ);
        son = 1'b0;
        req = 1'b0; // a later report needs a fresh rise
        cyc(4);
    endtask
    task automatic t_alarm();
        eev = 5'h01;
        gev = 1'b1;
        cyc(1);
        eev = '0;
        gev = 1'b0;
        gclr = 1'b1;
        cyc(3);
        gclr = 1'b0;
        cmp("gen alarm", 0, galm);
        cmp("enc kept", 5'h01, ealm);
        son = 1'b1;
        eclr = 1'b1;
        cyc(1);
        eclr = 1'b0;
        cyc(2);
        cmp("clear refused", 5'h01, ealm);
        son = 1'b0;
        eclr = 1'b1;
        cyc(1);
        eclr = 1'b0;
        cyc(2);
        cmp("enc clear", 0, ealm);
    endtask

    // =====================================================================
    // main sequence
    initial begin
        cyc(4);
        arst_n = 1'b1;
        cyc(2);
        cmp("valid reset", 0, valid);
        enc = '{a: 1'b0, b: 1'b1, z: 1'b1};
        cyc(3);
        cmp("origin", 1, pz);
        cmp("phase b", 1, pb);
        enc = '0;
        t_setup(1'b1);
        t_setup(1'b0);
        t_report("P+00000", 0);
        tdn = 1'b1;
        cyc(1);
        tdn = 1'b0;
        t_report("P-00001", -1);
        tdn = 1'b1;
        cyc(32768);
        tdn = 1'b0;
        t_report("P+32767", 32767);
        tup = 1'b1;
        cyc(1);
        tup = 1'b0;
        t_report("P-32768", -32768);
        t_alarm();
        lost = 1'b1;
        cyc(3);
        cmp("backup lost", 0, valid);
        close_out();
    end
    // watchdog
    initial begin
        cyc(100000);
        num_errors++;
        close_out();
    end
endmodule // test_apr_top

// file: hdl/apr_top.sv
`timescale 1ns/1ps
// =========================================================================
// absolute position report: serial turn count, initial pulses, then
// incremental pass-through; plus encoder alarm and multi-turn clear
module apr_top
    import apr_pkg::*;
#(
    parameter int REQ_DELAY_CYC  = APR_REQ_DELAY_CYC,
    parameter int NORM_DELAY_CYC = APR_NORM_DELAY_CYC,
    parameter int BIT_CYC        = APR_BIT_CYC,
    parameter int INIT_STEP_CYC  = APR_INIT_STEP_CYC
) (
    // clock and reset
    input  wire logic                      CLK,
    input  wire logic                      ARST_N,
    // report request pin from the host
    input  wire logic                      ABS_REPORT_REQUEST,
    // divided encoder signals and position inside the turn
    input  wire apr_quad_t                 ENC_IN,
    input  wire logic [16:0]               ENC_P0,
    input  wire logic                      ENC_TURN_UP,
    input  wire logic                      ENC_TURN_DN,
    input  wire logic                      ENC_BACKUP_LOST,
    // alarms and setup operations
    input  wire logic [APR_ENC_ALARMS-1:0] ENC_ALARM_EV,
    input  wire logic                      GEN_ALARM_EV,
    input  wire logic                      ENC_ALARM_CLEAR,
    input  wire logic                      GENERAL_ALARM_CLEAR_INPUT,
    input  wire logic                      MT_CLEAR_REQ,
    // servo control
    input  wire logic                      SERVO_ON,
    output logic                           SERVO_ENERGIZE,
    // pulse outputs to the host
    output logic                           PHASE_A_OUT,
    output logic                           PHASE_B_OUT,
    output logic                           ORIGIN_PULSE_OUT,
    // status
    output logic                           REPORT_BUSY,
    output logic                           ABS_DATA_VALID,
    output logic [APR_ENC_ALARMS-1:0]      ENC_ALARM,
    output logic                           GEN_ALARM,
    output logic                           SETUP_DONE,
    output logic                           SETUP_REFUSED
);

    apr_top_t s_q;
    apr_top_t s_d;
    logic     req_lvl_nx;
    logic     rise;
    logic     setup_ok;
    logic     alarm_clr_ok;
    logic     tx_ready;
    logic     tx_line;

    // =====================================================================
    // message character for a given position
    function automatic logic [6:0] msg_char(input logic [3:0] idx, input logic neg,
                                            input logic [4:0][3:0] dig);
        logic [3:0] d;
        d = 4'h0;
        unique case (idx)
            4'd0:    msg_char = APR_CH_P;
            4'd1:    msg_char = neg ? APR_CH_MINUS : APR_CH_PLUS;
            4'd7:    msg_char = APR_CH_CR;
            default: begin
                d        = dig[3'(idx - 4'd2)];
                msg_char = 7'(APR_CH_ZERO + {3'b000, d});
            end
        endcase
    endfunction

    // =====================================================================
    // request level counts only once the two late stages agree
    assign req_lvl_nx   = (s_q.sync[1] == s_q.sync[2]) ? s_q.sync[2] : s_q.req_lvl;
    assign rise         = req_lvl_nx & ~s_q.req_lvl;
    assign setup_ok     = MT_CLEAR_REQ & ~SERVO_ON;
    assign alarm_clr_ok = ENC_ALARM_CLEAR & ~SERVO_ON;

    // =====================================================================
    // serial character sender
    apr_uart_tx #(
        .BIT_CYC (BIT_CYC)
    ) u_tx (
        .clk    (CLK),
        .arst_n (ARST_N),
        .start  (s_q.tx_start),
        .data   (s_q.tx_char),
        .ready  (tx_ready),
        .line   (tx_line)
    );

    // =====================================================================
    // next state
    always_comb begin
        s_d               = s_q;
        s_d.setup_done    = 1'b0;
        s_d.setup_refused = 1'b0;
        s_d.tx_start      = 1'b0;
        s_d.sync          = {s_q.sync[1:0], ABS_REPORT_REQUEST};
        s_d.req_lvl       = req_lvl_nx;

        // turn count; clear wins, 16-bit add gives the documented wrap
        if (setup_ok) begin
            s_d.mt         = '0;
            s_d.valid      = 1'b1;
            s_d.setup_done = 1'b1;
        end else begin
            if (ENC_TURN_UP && !ENC_TURN_DN) begin
                s_d.mt = s_q.mt + 16'h0001;
            end else if (ENC_TURN_DN && !ENC_TURN_UP) begin
                s_d.mt = s_q.mt - 16'h0001;
            end
        end
        if ((MT_CLEAR_REQ || ENC_ALARM_CLEAR) && SERVO_ON) begin
            s_d.setup_refused = 1'b1;
        end
        if (ENC_BACKUP_LOST && !setup_ok) begin
            s_d.valid = 1'b0;
        end

        // sticky alarms: a new event beats a clear in the same cycle
        s_d.enc_alarm = (alarm_clr_ok ? '0 : s_q.enc_alarm) | ENC_ALARM_EV;
        s_d.gen_alarm = (GENERAL_ALARM_CLEAR_INPUT ? 1'b0 : s_q.gen_alarm) | GEN_ALARM_EV;

        // report sequence
        unique case (s_q.st)
            APR_NORMAL: begin
            end
            APR_WAIT: begin
                // decimal digits by subtraction, far quicker than the wait
                if (s_q.dig_idx < 3'(APR_DIGITS)) begin
                    if (s_q.mag >= APR_DEC_WEIGHT[s_q.dig_idx]) begin
                        s_d.mag                  = s_q.mag - APR_DEC_WEIGHT[s_q.dig_idx];
                        s_d.digits[s_q.dig_idx]  = s_q.digits[s_q.dig_idx] + 4'h1;
                    end else begin
                        s_d.dig_idx = s_q.dig_idx + 3'h1;
                    end
                end
                if (s_q.timer == '0) begin
                    s_d.st       = APR_SERIAL;
                    s_d.char_idx = '0;
                end else begin
                    s_d.timer = s_q.timer - 24'h00_0001;
                end
            end
            APR_SERIAL: begin
                // tx_start blocks a second issue while ready still lags
                if (tx_ready && !s_q.tx_start) begin
                    if (s_q.char_idx == 4'(APR_MSG_LEN)) begin
                        s_d.st       = APR_INIT;
                        s_d.timer    = 24'(NORM_DELAY_CYC - 1);
                        s_d.pulses   = s_q.p0;
                        s_d.step_tmr = 8'(INIT_STEP_CYC - 1);
                        s_d.quad     = APR_QUAD_START;
                    end else begin
                        s_d.tx_start = 1'b1;
                        s_d.tx_char  = msg_char(s_q.char_idx, s_q.neg, s_q.digits);
                        s_d.char_idx = s_q.char_idx + 4'h1;
                    end
                end
            end
            APR_INIT: begin
                if (s_q.pulses != '0) begin
                    if (s_q.step_tmr == '0) begin
                        s_d.quad     = {~s_q.quad[0], s_q.quad[1]};
                        s_d.pulses   = s_q.pulses - 17'h0_0001;
                        s_d.step_tmr = 8'(INIT_STEP_CYC - 1);
                    end else begin
                        s_d.step_tmr = s_q.step_tmr - 8'h01;
                    end
                end
                if (s_q.timer != '0) begin
                    s_d.timer = s_q.timer - 24'h00_0001;
                end else if (s_q.pulses == '0) begin
                    s_d.st       = APR_NORMAL;
                    s_d.rpt_done = 1'b1;
                end
            end
        endcase

        // a fresh request restarts the whole report from any phase
        if (rise) begin
            s_d.st      = APR_WAIT;
            s_d.timer   = 24'(REQ_DELAY_CYC - 1);
            s_d.neg     = s_q.mt[15];
            s_d.mag     = s_q.mt[15] ? (16'h0000 - s_q.mt) : s_q.mt;
            s_d.p0      = ENC_P0;
            s_d.dig_idx = '0;
            s_d.digits  = '0;
        end

        // output pins, registered
        s_d.q_out.z = ENC_IN.z;
        unique case (s_q.st)
            APR_NORMAL: begin
                s_d.q_out.a = ENC_IN.a;
                s_d.q_out.b = ENC_IN.b;
            end
            APR_WAIT: begin
                s_d.q_out.a = 1'b1;
                s_d.q_out.b = 1'b0;
            end
            APR_SERIAL: begin
                s_d.q_out.a = tx_line;
                s_d.q_out.b = 1'b0;
            end
            APR_INIT: begin
                s_d.q_out.a = s_q.quad[1];
                s_d.q_out.b = s_q.quad[0];
            end
        endcase

        // no torque until a report has completed and nothing is wrong
        s_d.energize = SERVO_ON && s_q.st == APR_NORMAL && s_q.rpt_done && s_q.valid
                       && s_q.enc_alarm == '0 && !s_q.gen_alarm;
    end

    // =====================================================================
    // state register
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s_q <= APR_TOP_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // =====================================================================
    // ports
    assign PHASE_A_OUT      = s_q.q_out.a;
    assign PHASE_B_OUT      = s_q.q_out.b;
    assign ORIGIN_PULSE_OUT = s_q.q_out.z;
    assign SERVO_ENERGIZE   = s_q.energize;
    assign REPORT_BUSY      = s_q.st != APR_NORMAL;
    assign ABS_DATA_VALID   = s_q.valid;
    assign ENC_ALARM        = s_q.enc_alarm;
    assign GEN_ALARM        = s_q.gen_alarm;
    assign SETUP_DONE       = s_q.setup_done;
    assign SETUP_REFUSED    = s_q.setup_refused;

    // =====================================================================
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    a_rise_restart: assert property (rise |=> (s_q.st == APR_WAIT && s_q.timer == 24'(REQ_DELAY_CYC - 1)))
        else $error("request edge did not restart report");
    a_wait_exit: assert property ((s_q.st == APR_WAIT && s_q.timer == '0 && !rise) |=> s_q.st == APR_SERIAL)
        else $error("serial phase not started after delay");
    a_msg_eight: assert property ((s_q.st == APR_SERIAL ##1 s_q.st == APR_INIT) |-> $past(s_q.char_idx) == 4'd8)
        else $error("message not eight characters");
    a_norm_delay: assert property ((s_q.st == APR_INIT && s_q.timer != '0 && !rise) |=> s_q.st == APR_INIT)
        else $error("left initial phase before delay");
    a_step_rate: assert property ((s_q.st == APR_INIT && s_q.step_tmr != '0) |=> $stable(s_q.quad))
        else $error("initial pulse faster than step rate");
    a_line_idle: assert property ((s_q.st == APR_WAIT) |=> PHASE_A_OUT)
        else $error("serial line not at mark before message");
    a_origin_pass: assert property (1'b1 |=> ORIGIN_PULSE_OUT == $past(ENC_IN.z))
        else $error("origin output not following encoder");
    a_no_energize: assert property ((s_q.st != APR_NORMAL) |=> !SERVO_ENERGIZE)
        else $error("energized during report");
    a_setup_refused: assert property ((MT_CLEAR_REQ && SERVO_ON) |=> (SETUP_REFUSED && !SETUP_DONE))
        else $error("setup accepted with servo on");
    a_mt_cleared: assert property ((MT_CLEAR_REQ && !SERVO_ON) |=> (s_q.mt == '0 && SETUP_DONE && ABS_DATA_VALID))
        else $error("multi-turn clear failed");
    a_alarm_hold: assert property (!alarm_clr_ok |=> (ENC_ALARM & $past(ENC_ALARM)) == $past(ENC_ALARM))
        else $error("encoder alarm lost without its clear");
    a_mt_wrap: assert property ((s_q.mt == 16'h7FFF && ENC_TURN_UP && !ENC_TURN_DN && !setup_ok)
        |=> s_q.mt == 16'h8000) else $error("turn count did not wrap");
    a_data_invalid: assert property ((ENC_BACKUP_LOST && !setup_ok) |=> !ABS_DATA_VALID)
        else $error("data valid after backup loss");

endmodule // apr_top

// file: hdl/apr_uart_tx.sv
`timescale 1ns/1ps
// =========================================================================
// async character sender, 7 data bits lsb first, even parity
module apr_uart_tx
    import apr_pkg::*;
#(
    parameter int BIT_CYC = APR_BIT_CYC
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // character request
    input  wire logic       start,
    input  wire logic [6:0] data,
    output logic            ready,
    // serial line
    output logic            line
);

    apr_tx_t s_q;
    apr_tx_t s_d;

    // ready only in idle, so a start while busy is ignored
    assign ready = ~s_q.busy;
    assign line  = s_q.line;

    // =====================================================================
    // next state
    always_comb begin
        s_d = s_q;
        if (!s_q.busy) begin
            s_d.line = 1'b1;
            if (start) begin
                s_d.busy  = 1'b1;
                s_d.line  = 1'b0;
                s_d.sh    = {1'b1, ^data, data};
                s_d.nbits = 4'(APR_FRAME_BITS - 1);
                s_d.tmr   = 24'(BIT_CYC - 1);
            end
        end else if (s_q.tmr != '0) begin
            s_d.tmr = s_q.tmr - 24'h0001;
        end else if (s_q.nbits != '0) begin
            s_d.line  = s_q.sh[0];
            s_d.sh    = {1'b1, s_q.sh[8:1]};
            s_d.nbits = s_q.nbits - 4'h1;
            s_d.tmr   = 24'(BIT_CYC - 1);
        end else begin
            // stop bit has stood a full bit time
            s_d.busy = 1'b0;
            s_d.line = 1'b1;
        end
    end

    // =====================================================================
    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= APR_TX_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_tx_start_bit: assert property ((start && ready) |=> (!line && busy_hold()))
        else $error("no start bit");
    a_tx_idle_mark: assert property (ready |-> ##1 (line || s_q.busy))
        else $error("idle line not at mark");

    function automatic logic busy_hold();
        return s_q.busy && s_q.nbits == 4'(APR_FRAME_BITS - 1);
    endfunction

endmodule // apr_uart_tx

// file: inc/apr_pkg.sv
// What this block does
// - phase A: serial data, initial pulses, then incremental; B pulses; origin always
// - serial phase starts 100 ms after the request goes high
// - message is exactly 8 characters and host accepts all of them
// - normal incremental output starts 25 ms after the last character, or after the last initial pulse if that is later
// - initial pulses go out at the rate of 1250 rpm rotation
// - 9600 bps async: start, 7 ASCII bits, even parity, stop
// - message is P, sign, five digits, carriage return; zero keeps a sign
// - turn count wraps between +32767 and -32768 both ways
// - encoder setup only allowed while servo is off
// - encoder alarms clear only by the encoder clear, not general reset
// - multi-turn clear zeroes the count and reports completion
// - loss of control power and battery invalidates data until setup
// - every low-to-high request repeats serial data and initial pulses
// - motor stays de-energized until the report sequence completes
package apr_pkg;

    // =====================================================================
    // timing
    localparam int     APR_CLK_HZ          = 100_000_000;
    localparam int     APR_REQ_DELAY_MS    = 100;
    localparam int     APR_REQ_DELAY_CYC   = APR_CLK_HZ / 1000 * APR_REQ_DELAY_MS;
    localparam int     APR_NORM_DELAY_MS   = 25;
    localparam int     APR_NORM_DELAY_CYC  = APR_CLK_HZ / 1000 * APR_NORM_DELAY_MS;
    localparam int     APR_BAUD            = 9600;
    localparam int     APR_BIT_CYC         = APR_CLK_HZ / APR_BAUD;
    localparam int     APR_INIT_RPM        = 1250;
    localparam int     APR_PULSES_PER_REV  = 131072;
    localparam longint APR_INIT_STEP_L     = (longint'(APR_CLK_HZ) * 60)
                                             / (longint'(APR_INIT_RPM) * APR_PULSES_PER_REV);
    localparam int     APR_INIT_STEP_CYC   = int'(APR_INIT_STEP_L);

    // =====================================================================
    // message and frame layout
    localparam int           APR_MSG_LEN    = 8;
    localparam int           APR_DIGITS     = 5;
    localparam int           APR_FRAME_BITS = 10;
    localparam logic [6:0]   APR_CH_P       = 7'h50;
    localparam logic [6:0]   APR_CH_PLUS    = 7'h2B;
    localparam logic [6:0]   APR_CH_MINUS   = 7'h2D;
    localparam logic [6:0]   APR_CH_ZERO    = 7'h30;
    localparam logic [6:0]   APR_CH_CR      = 7'h0D;
    localparam logic [4:0][15:0] APR_DEC_WEIGHT = {16'h0001, 16'h000A, 16'h0064, 16'h03E8, 16'h2710};
    localparam logic [1:0]   APR_QUAD_START = 2'b10;

    // =====================================================================
    // encoder alarm bit positions
    localparam int APR_ALM_MT_ERR  = 0;
    localparam int APR_ALM_MT_OVF  = 1;
    localparam int APR_ALM_BATT1   = 2;
    localparam int APR_ALM_BATT2   = 3;
    localparam int APR_ALM_OVSPD   = 4;
    localparam int APR_ENC_ALARMS  = 5;

    // =====================================================================
    // types
    typedef enum logic [1:0] {
        APR_NORMAL = 2'b00,
        APR_WAIT   = 2'b01,
        APR_SERIAL = 2'b10,
        APR_INIT   = 2'b11
    } apr_rpt_t;

    typedef struct packed {
        logic a;
        logic b;
        logic z;
    } apr_quad_t;

    typedef struct packed {
        logic        busy;
        logic [8:0]  sh;
        logic [3:0]  nbits;
        logic [23:0] tmr;
        logic        line;
    } apr_tx_t;

    typedef struct packed {
        logic [2:0]                      sync;
        logic                            req_lvl;
        apr_rpt_t                        st;
        logic [23:0]                     timer;
        logic [15:0]                     mag;
        logic                            neg;
        logic [2:0]                      dig_idx;
        logic [4:0][3:0]                 digits;
        logic [3:0]                      char_idx;
        logic                            tx_start;
        logic [6:0]                      tx_char;
        logic [16:0]                     p0;
        logic [16:0]                     pulses;
        logic [7:0]                      step_tmr;
        logic [1:0]                      quad;
        logic [15:0]                     mt;
        logic                            valid;
        logic                            rpt_done;
        logic [APR_ENC_ALARMS-1:0]       enc_alarm;
        logic                            gen_alarm;
        logic                            setup_done;
        logic                            setup_refused;
        apr_quad_t                       q_out;
        logic                            energize;
    } apr_top_t;

    localparam apr_tx_t  APR_TX_RESET  = '{busy: 1'b0, sh: '0, nbits: '0, tmr: '0, line: 1'b1};
    localparam apr_top_t APR_TOP_RESET = '0;

endpackage
